// ==== bench/aux_sink_model.sv ====
// behavioural sink that answers each request except in mode 1
`timescale 1ns/1ps
`default_nettype none
module aux_sink_model #(parameter int HALF = 4) (
    input  wire logic       clk_i,
    input  wire logic       oe_n_i,
    input  wire logic [1:0] mode_i,
    input  wire logic [4:0] nbytes_i,
    input  wire logic       slow_i,
    output logic            drv_o,
    output logic            val_o
);
    // one half bit at level v
    task automatic half(input logic v);
        val_o <= v;
        repeat (HALF) @(posedge clk_i);
    endtask : half
    // n bits of b, msb first, manchester coded
    task automatic bits(input logic [7:0] b, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            half(b[i]);
            half(!b[i]);
        end
    endtask : bits
    // mode 1 silent, mode 2 ends on half a byte
    initial begin
        drv_o = 1'b0;
        val_o = 1'b0;
        forever begin
            @(posedge oe_n_i);
            repeat (slow_i ? 150 : 10) @(posedge clk_i);
            if (mode_i != 2'h1) begin
                drv_o <= 1'b1;
                bits(8'h00, 2);
                repeat (4) half(1'b1);
                repeat (4) half(1'b0);
                for (int k = 0; k < nbytes_i; k++) bits(8'hc3 ^ k[7:0], 8);
                if (mode_i == 2'h2) bits(8'h5a, 4);
                repeat (4) half(1'b1);
                drv_o <= 1'b0;
                val_o <= 1'b0;
            end
        end
    end
endmodule : aux_sink_model
`default_nettype wire

// ==== bench/dp_aux_channel_requester_bench.sv ====
// self-checking bench for the aux requester
`timescale 1ns/1ps
`default_nettype none
module dp_aux_channel_requester_bench;
    localparam int DIV = 4;
    localparam int TMO [4] = '{200, 300, 400, 800};
    logic        REF_CLK_I = 1'b0;
    logic        RSTN_I = 1'b0;
    logic        CE_I = 1'b1;
    logic        REG_WR_I = 1'b0;
    logic        REG_RD_I = 1'b0;
    logic [2:0]  REG_IDX_I = 3'h0;
    logic [31:0] REG_WDATA_I = 32'h0;
    logic [31:0] REG_RDATA_O, rd;
    logic        AUX_IRQ_O, AUX_OUT_O, AUX_OE_N_O, AUX_IN_I, drv, val;
    logic        slow = 1'b0;
    logic [1:0]  mode = 2'h1;
    logic [4:0]  nb = 5'h0;
    logic [7:0]  req;
    int num_errors = 0, num_checks = 0, cyc = 0, gap, idle = 0;
    int rises, hi, pre_seen = -1, since = -1;
    always #12.5 REF_CLK_I = ~REF_CLK_I;
    // released wire is pulled low
    assign AUX_IN_I = !AUX_OE_N_O ? AUX_OUT_O : (drv ? val : 1'b0);
    dp_aux_channel_requester #(.TMO0_CYCLES(TMO[0]), .TMO1_CYCLES(TMO[1]),
        .TMO2_CYCLES(TMO[2]), .TMO3_CYCLES(TMO[3])) DUT (.REF_CLK_I, .RSTN_I,
        .CE_I, .REG_WR_I, .REG_RD_I, .REG_IDX_I, .REG_WDATA_I, .REG_RDATA_O,
        .AUX_IRQ_O, .AUX_IN_I, .AUX_OUT_O, .AUX_OE_N_O);
    aux_sink_model #(.HALF(DIV)) sink (.clk_i(REF_CLK_I), .oe_n_i(AUX_OE_N_O),
        .mode_i(mode), .nbytes_i(nb), .slow_i(slow), .drv_o(drv), .val_o(val));
    // counts precharge rises and captures the first request byte
    always @(posedge REF_CLK_I) begin
        if (AUX_IRQ_O) gap = idle;
        if (AUX_OE_N_O) idle++;
        else begin
            if (idle > 0) begin
                rises = 0;
                hi = 0;
                pre_seen = -1;
                since = -1;
            end
            idle = 0;
            rises += int'(AUX_OUT_O && hi == 0);
            hi = AUX_OUT_O ? hi + 1 : 0;
            if (hi == 3 * DIV && pre_seen < 0) pre_seen = rises;
            if (pre_seen >= 0 && since < 0 && !AUX_OUT_O) since = 0;
            if (since >= 0) begin
                if (since >= 4 * DIV && since < 20 * DIV
                    && since % (2 * DIV) == DIV / 2) req = {req[6:0], AUX_OUT_O};
                since++;
            end
        end
    end
    // hang guard
    always @(posedge REF_CLK_I) if (++cyc == 20000) begin
        num_errors++;
        results();
    end
    task automatic check(input string what, input logic [31:0] exp, got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic reg_wr(input logic [2:0] idx, input logic [31:0] d);
        @(posedge REF_CLK_I);
        REG_WR_I <= 1'b1;
        REG_IDX_I <= idx;
        REG_WDATA_I <= d;
        @(posedge REF_CLK_I);
        REG_WR_I <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [2:0] idx, output logic [31:0] d);
        @(posedge REF_CLK_I);
        REG_RD_I <= 1'b1;
        REG_IDX_I <= idx;
        @(posedge REF_CLK_I);
        REG_RD_I <= 1'b0;
        @(negedge REF_CLK_I);
        d = REG_RDATA_O;
    endtask : reg_rd
    function automatic logic [31:0] ctl(logic go, logic [2:0] w, logic [1:0] ts,
                                        logic [4:0] sz, logic [3:0] pre);
        return {go, w[2], 1'b1, w[1], ts, w[0], sz, pre, 5'h0, 11'(DIV)};
    endfunction : ctl
    // start, poke while busy, wait for the end, judge and clear the flags
    task automatic transact(input logic [1:0] ts, input logic [4:0] sz,
        input logic [3:0] pre, input logic [2:0] fl, input logic [4:0] rsz);
        int n;
        logic [31:0] m;
        n = 0;
        m = (fl == 3'b100) ? 32'hffffffff : 32'hfe0fffff;
        reg_wr(3'h0, ctl(1'b1, 3'h0, ts, sz, pre));
        if (sz != 5'h0 && sz <= 5'h14) begin
            reg_rd(3'h0, rd);
            check("busy", 32'h1, 32'(rd[31]));
            reg_wr(3'h0, 32'h0);
            CE_I <= 1'b0;
            repeat (5) @(posedge REF_CLK_I);
            CE_I <= 1'b1;
        end
        while (AUX_IRQ_O !== 1'b1 && n < 5000) begin
            @(posedge REF_CLK_I);
            n++;
        end
        check("interrupt", 32'h1, 32'(n < 5000));
        reg_rd(3'h0, rd);
        check("control", ctl(1'b0, fl, ts, rsz, pre) & m, rd & m);
        reg_wr(3'h0, ctl(1'b0, 3'h7, ts, sz, pre));
        reg_rd(3'h0, rd);
        check("cleared", 32'h0, rd & 32'h52000000);
    endtask : transact
    task automatic t_reset;
        reg_rd(3'h0, rd);
        check("reset control", 32'h00050014, rd);
        for (int i = 1; i < 8; i++) begin
            reg_rd(3'(i), rd);
            check("reset word", 32'h0, rd);
        end
        reg_wr(3'h6, 32'hffffffff);
        reg_rd(3'h6, rd);
        check("unmapped", 32'h0, rd);
    endtask : t_reset
    task automatic t_normal;
        mode = 2'h0;
        nb = 5'h4;
        reg_wr(3'h1, 32'ha1b2c3d4);
        transact(2'h0, 5'h4, 4'h3, 3'b100, 5'h4);
        check("precharge pulses", 32'd32, 32'(pre_seen));
        check("first byte", 32'ha1, {24'h0, req});
        reg_rd(3'h1, rd);
        check("reply word", 32'hc3c2c1c0, rd);
    endtask : t_normal
    task automatic t_timeout;
        mode = 2'h1;
        for (int k = 0; k < 4; k++) begin
            transact(2'(k), 5'h1, 4'h0, 3'b110, 5'h0);
            check("wait", 32'h1, 32'(gap > TMO[k] - 3 && gap < TMO[k] + 7));
        end
    endtask : t_timeout
    task automatic t_errors;
        mode = 2'h2;
        nb = 5'h1;
        transact(2'h0, 5'h1, 4'h0, 3'b101, 5'h0);
        mode = 2'h0;
        nb = 5'h15;
        transact(2'h0, 5'h1, 4'h0, 3'b101, 5'h0);
        mode = 2'h1;
        transact(2'h0, 5'h0, 4'h0, 3'b101, 5'h0);
        transact(2'h0, 5'h15, 4'h0, 3'b101, 5'h0);
    endtask : t_errors
    task automatic t_slow;
        mode = 2'h0;
        nb = 5'h2;
        slow = 1'b1;
        transact(2'h1, 5'h3, 4'h0, 3'b100, 5'h2);
    endtask : t_slow
    task automatic results;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : results
    initial begin
        repeat (3) @(posedge REF_CLK_I);
        RSTN_I <= 1'b1;
        t_reset();
        t_normal();
        t_timeout();
        t_errors();
        t_slow();
        results();
    end
endmodule : dp_aux_channel_requester_bench
bind dp_aux_channel_requester dp_aux_checker chk (.REF_CLK_I, .RSTN_I, .CE_I,
    .REG_RD_I, .REG_IDX_I, .REG_RDATA_O, .AUX_IRQ_O, .AUX_OUT_O, .AUX_OE_N_O);
`default_nettype wire

// ==== bench/dp_aux_checker.sv ====
// port checker for the aux requester
`timescale 1ns/1ps
`default_nettype none
module dp_aux_checker (
    input wire logic        REF_CLK_I,
    input wire logic        RSTN_I,
    input wire logic        CE_I,
    input wire logic        REG_RD_I,
    input wire logic [2:0]  REG_IDX_I,
    input wire logic [31:0] REG_RDATA_O,
    input wire logic        AUX_IRQ_O,
    input wire logic        AUX_OUT_O,
    input wire logic        AUX_OE_N_O
);
    // one clock domain, checks off while reset is low
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RSTN_I);
    irq_pulse_a: assert property (AUX_IRQ_O && CE_I |=> !AUX_IRQ_O)
        else $error("interrupt longer than one cycle");
    irq_released_a: assert property (AUX_IRQ_O |-> AUX_OE_N_O)
        else $error("transaction ended while line driven");
    release_low_a: assert property (AUX_OE_N_O |-> !AUX_OUT_O)
        else $error("released line not low");
    prechg_low_a: assert property ($fell(AUX_OE_N_O) |-> !AUX_OUT_O)
        else $error("precharge does not open with low half");
    drive_hold_a: assert property ($fell(AUX_OE_N_O) |-> !AUX_OE_N_O [*8])
        else $error("drive window too short");
    freeze_a: assert property (!CE_I |=> $stable(AUX_OUT_O))
        else $error("line moved with clock enable low");
    rdata_hold_a: assert property (!(REG_RD_I && CE_I) |=> $stable(REG_RDATA_O))
        else $error("read data changed without read");
    unmapped_a: assert property (REG_RD_I && CE_I && REG_IDX_I > 3'h5
        |=> REG_RDATA_O == 32'h0)
        else $error("unmapped index read nonzero");
    busy_read_a: assert property (REG_RD_I && CE_I && REG_IDX_I == 3'h0
        && !AUX_OE_N_O |=> REG_RDATA_O[31])
        else $error("busy clear while line driven");
endmodule : dp_aux_checker
`default_nettype wire

// ==== logic/aux_bit_clock_divider.sv ====
// divides the reference clock into half-bit ticks for the aux channel
`timescale 1ns/1ps
`default_nettype none
module aux_bit_clock_divider (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    input  wire logic [10:0] divisor_i,
    input  wire logic        restart_i,
    input  wire logic [10:0] preset_i,
    output logic             tick_o
);
    logic [10:0] cnt;      // reference cycles within a half bit
    logic [10:0] last;     // terminal count, never below zero

    // a divisor of zero behaves as one
    assign last = (divisor_i == 11'h000) ? 11'h000 : divisor_i - 11'h001;

    // count and tick; a restart lets callers pick the tick phase
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt    <= 11'h000;
            tick_o <= 1'b0;
        end else if (ce_i) begin
            if (restart_i) begin
                cnt    <= preset_i;
                tick_o <= 1'b0;
            end else if (cnt >= last) begin
                cnt    <= 11'h000;
                tick_o <= 1'b1;
            end else begin
                cnt    <= cnt + 11'h001;
                tick_o <= 1'b0;
            end
        end
    end
endmodule : aux_bit_clock_divider
`default_nettype wire

// ==== logic/dp_aux_channel_requester.sv ====
// aux channel requester: control and data registers, serialiser, receiver
//
// Overview of operation
// - writing busy bit starts; reads one till end
// - ends on full reply, timeout or receive error
// - writing zero to busy does nothing
// - sticky done flag, write one clears
// - enabled interrupt on completion, timeout or receive error
// - sticky timeout flag, write one clears
// - two-bit field picks 400/600/800/1600us wait
// - sticky receive error on bad reply data or bad size
// - precharge sends 26 plus per-microsecond pulses
// - precharge field counts two-microsecond units, reset 5
// - eleven-bit divisor makes double bit rate clock
// - divider runs from the reference clock, gated by CE_I
// - request bytes come from five data words
// - most significant byte of each word first
// - data words return reply bytes after completion
`timescale 1ns/1ps
`default_nettype none
`include "dp_aux_regs.svh"
module dp_aux_channel_requester #(
    parameter int unsigned TMO0_CYCLES = `AUX_TMO0_US * `AUX_REF_CLK_MHZ,
    parameter int unsigned TMO1_CYCLES = `AUX_TMO1_US * `AUX_REF_CLK_MHZ,
    parameter int unsigned TMO2_CYCLES = `AUX_TMO2_US * `AUX_REF_CLK_MHZ,
    parameter int unsigned TMO3_CYCLES = `AUX_TMO3_US * `AUX_REF_CLK_MHZ
) (
    input  wire logic        REF_CLK_I,
    input  wire logic        RSTN_I,
    input  wire logic        CE_I,
    input  wire logic        REG_WR_I,
    input  wire logic        REG_RD_I,
    input  wire logic [2:0]  REG_IDX_I,
    input  wire logic [31:0] REG_WDATA_I,
    output logic [31:0]      REG_RDATA_O,
    output logic             AUX_IRQ_O,
    input  wire logic        AUX_IN_I,
    output logic             AUX_OUT_O,
    output logic             AUX_OE_N_O
);
    dp_aux_pkg::aux_state_t state;     // sequencer state
    dp_aux_pkg::aux_ctl_t   ctl;       // control fields
    dp_aux_pkg::aux_flags_t flags;     // sticky flags
    logic [31:0] data_word [0:4];      // request and reply bytes
    logic        tick;                 // half-bit tick
    logic        ph;                   // second half of a bit
    logic [5:0]  cnt;                  // pulse or half counter
    logic [2:0]  bit_cnt;              // bit within byte, counts down
    logic [4:0]  byte_idx;             // byte being sent
    logic [4:0]  rx_count;             // reply bytes stored
    logic [6:0]  rx_shift;             // reply bits so far
    logic        first_half;           // sampled first half level
    logic [16:0] tmo_cnt;              // reference cycles since release
    logic [12:0] run_cnt;              // length of current high level
    logic        busy;                 // transaction in flight
    logic        wr_ctl;               // control register write
    logic        start_go;             // accepted start
    logic        fin_ok;               // reply received
    logic        fin_tmo;              // wait expired
    logic        fin_err;              // bad reply or bad size
    logic        fin_any;              // transaction ends
    logic        rx_store;             // reply byte complete
    logic        sync_hit;             // reply sync found
    logic        div_restart;          // realign divider phase
    logic [10:0] div_preset;           // divider phase after realign
    logic [16:0] tmo_limit;            // selected wait in cycles
    logic [12:0] sync_thr;             // three half bits
    logic [5:0]  pre_pulses;           // total precharge pulses
    logic        tx_bit;               // bit being serialised

    // bit offset of a byte lane, most significant byte at index 0
    function automatic logic [4:0] lane_base(input logic [4:0] idx);
        lane_base = {~idx[1:0], 3'h0};
    endfunction : lane_base

    // true for one of the five data word indices
    function automatic logic is_data_idx(input logic [2:0] idx);
        is_data_idx = (idx >= `AUX_IDX_DATA0) && (idx <= `AUX_IDX_DATA4);
    endfunction : is_data_idx

    assign busy   = (state != dp_aux_pkg::ST_IDLE);
    assign wr_ctl = REG_WR_I && (REG_IDX_I == `AUX_IDX_CTL);
    assign start_go = wr_ctl && REG_WDATA_I[`AUX_BIT_BUSY] && !busy;
    assign pre_pulses = `AUX_PRE_FIXED + {1'b0, ctl.precharge, 1'b0};
    assign sync_thr = {2'h0, ctl.double_rate_divisor}
                    + {1'b0, ctl.double_rate_divisor, 1'b0};
    assign tx_bit = data_word[byte_idx[4:2]][lane_base(byte_idx)
                                             + {2'h0, bit_cnt}];
    assign fin_any = fin_ok || fin_tmo || fin_err;

    always_comb begin
        unique case (ctl.tmo_sel)
            2'h0: tmo_limit = 17'(TMO0_CYCLES);
            2'h1: tmo_limit = 17'(TMO1_CYCLES);
            2'h2: tmo_limit = 17'(TMO2_CYCLES);
            2'h3: tmo_limit = 17'(TMO3_CYCLES);
        endcase
    end

    // end-of-transaction and reply events
    always_comb begin
        fin_ok      = 1'b0;
        fin_tmo     = 1'b0;
        fin_err     = 1'b0;
        rx_store    = 1'b0;
        sync_hit    = 1'b0;
        div_restart = start_go;
        div_preset  = 11'h000;
        if (start_go && (REG_WDATA_I[`AUX_SIZE_HI:`AUX_SIZE_LO] == 5'h00 ||
            REG_WDATA_I[`AUX_SIZE_HI:`AUX_SIZE_LO] > `AUX_MAX_BYTES)) begin
            fin_err = 1'b1;
        end
        if (state == dp_aux_pkg::ST_LISTEN) begin
            if (tmo_cnt >= tmo_limit) begin
                fin_tmo = 1'b1;
            end else if (!AUX_IN_I && run_cnt >= sync_thr) begin
                // sync end found: ticks land mid half from here
                sync_hit    = 1'b1;
                div_restart = 1'b1;
                div_preset  = {1'b0, ctl.double_rate_divisor[10:1]};
            end
        end
        if (state == dp_aux_pkg::ST_RECEIVE && tick && cnt[2] && ph) begin
            if (first_half == AUX_IN_I) begin
                if (AUX_IN_I && bit_cnt == 3'h7 && rx_count != 5'h00) begin
                    fin_ok = 1'b1;
                end else begin
                    fin_err = 1'b1;
                end
            end else if (bit_cnt == 3'h0) begin
                if (rx_count == `AUX_MAX_BYTES) begin
                    fin_err = 1'b1;
                end else begin
                    rx_store = 1'b1;
                end
            end
        end
    end

    aux_bit_clock_divider u_div (
        .clk_i     (REF_CLK_I),
        .rst_n_i   (RSTN_I),
        .ce_i      (CE_I),
        .divisor_i (ctl.double_rate_divisor),
        .restart_i (div_restart),
        .preset_i  (div_preset),
        .tick_o    (tick)
    );

    // sequencer: precharge, sync, data, stop, listen, receive
    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            state      <= dp_aux_pkg::ST_IDLE;
            ph         <= 1'b0;
            cnt        <= 6'h00;
            bit_cnt    <= 3'h7;
            byte_idx   <= 5'h00;
            AUX_OUT_O  <= 1'b0;
            AUX_OE_N_O <= 1'b1;
        end else if (CE_I) begin
            unique case (state)
                dp_aux_pkg::ST_IDLE: begin
                    if (start_go && !fin_err) begin
                        state    <= dp_aux_pkg::ST_PRECHG;
                        ph       <= 1'b0;
                        cnt      <= 6'h00;
                        bit_cnt  <= 3'h7;
                        byte_idx <= 5'h00;
                    end
                end
                dp_aux_pkg::ST_PRECHG: if (tick) begin
                    AUX_OE_N_O <= 1'b0;
                    AUX_OUT_O  <= ph;
                    ph         <= !ph;
                    if (ph) begin
                        cnt <= cnt + 6'h01;
                        if (cnt == pre_pulses - 6'h01) begin
                            state <= dp_aux_pkg::ST_SYNC;
                            cnt   <= 6'h00;
                        end
                    end
                end
                // sync end: two microseconds high, two low
                dp_aux_pkg::ST_SYNC: if (tick) begin
                    AUX_OUT_O <= (cnt[3:0] < `AUX_SYNC_HIGH);
                    cnt       <= cnt + 6'h01;
                    if (cnt[3:0] == `AUX_SYNC_HALVES - 4'h1) begin
                        state <= dp_aux_pkg::ST_DATA;
                        cnt   <= 6'h00;
                    end
                end
                dp_aux_pkg::ST_DATA: if (tick) begin
                    AUX_OUT_O <= ph ? !tx_bit : tx_bit;
                    ph        <= !ph;
                    if (ph) begin
                        bit_cnt <= bit_cnt - 3'h1;
                        if (bit_cnt == 3'h0) begin
                            byte_idx <= byte_idx + 5'h01;
                            if (byte_idx == ctl.size - 5'h01) begin
                                state <= dp_aux_pkg::ST_STOP;
                            end
                        end
                    end
                end
                // stop pattern, then the line is let go
                dp_aux_pkg::ST_STOP: if (tick) begin
                    AUX_OUT_O <= (cnt[3:0] < `AUX_SYNC_HIGH);
                    cnt       <= cnt + 6'h01;
                    if (cnt[3:0] == `AUX_SYNC_HALVES) begin
                        AUX_OE_N_O <= 1'b1;
                        AUX_OUT_O  <= 1'b0;
                        state      <= dp_aux_pkg::ST_LISTEN;
                        cnt        <= 6'h00;
                    end
                end
                dp_aux_pkg::ST_LISTEN: begin
                    if (fin_tmo) begin
                        state <= dp_aux_pkg::ST_IDLE;
                    end else if (sync_hit) begin
                        state   <= dp_aux_pkg::ST_RECEIVE;
                        ph      <= 1'b0;
                        cnt     <= 6'h00;
                        bit_cnt <= 3'h7;
                    end
                end
                // skip the sync low, then two samples per bit
                dp_aux_pkg::ST_RECEIVE: begin
                    if (fin_any) begin
                        state <= dp_aux_pkg::ST_IDLE;
                    end else if (tick && !cnt[2]) begin
                        cnt <= cnt + 6'h01;
                    end else if (tick) begin
                        ph <= !ph;
                        if (ph) begin
                            bit_cnt <= bit_cnt - 3'h1;
                        end
                    end
                end
            endcase
        end
    end

    // reply receive capture and wait counters
    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            tmo_cnt    <= 17'h00000;
            run_cnt    <= 13'h0000;
            rx_count   <= 5'h00;
            rx_shift   <= 7'h00;
            first_half <= 1'b0;
        end else if (CE_I) begin
            if (start_go) begin
                rx_count <= 5'h00;
            end
            if (state != dp_aux_pkg::ST_LISTEN) begin
                tmo_cnt <= 17'h00000;
                run_cnt <= 13'h0000;
            end else begin
                tmo_cnt <= tmo_cnt + 17'h00001;
                // saturating length of the current high level
                if (!AUX_IN_I) begin
                    run_cnt <= 13'h0000;
                end else if (run_cnt != 13'h1fff) begin
                    run_cnt <= run_cnt + 13'h0001;
                end
            end
            if (state == dp_aux_pkg::ST_RECEIVE && tick && cnt[2]) begin
                if (!ph) begin
                    first_half <= AUX_IN_I;
                end else begin
                    rx_shift <= {rx_shift[5:0], first_half};
                end
            end
            if (rx_store) begin
                rx_count <= rx_count + 5'h01;
            end
        end
    end

    // data words: software writes when idle, reply bytes land in place
    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            for (int i = 0; i < 5; i++) begin
                data_word[i] <= `AUX_RST_DATA;
            end
        end else if (CE_I) begin
            if (REG_WR_I && !busy && is_data_idx(REG_IDX_I)) begin
                data_word[REG_IDX_I - `AUX_IDX_DATA0] <= REG_WDATA_I;
            end
            if (rx_store) begin
                data_word[rx_count[4:2]][lane_base(rx_count) +: 8]
                    <= {rx_shift, first_half};
            end
        end
    end

    // control fields; ignored while busy
    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ctl.irq_en              <= 1'b0;
            ctl.tmo_sel             <= `AUX_RST_TMO_SEL;
            ctl.size                <= `AUX_RST_SIZE;
            ctl.precharge           <= `AUX_RST_PRE;
            ctl.double_rate_divisor <= `AUX_RST_DIV;
        end else if (CE_I) begin
            if (wr_ctl && !busy) begin
                ctl.irq_en    <= REG_WDATA_I[`AUX_BIT_IRQ_EN];
                ctl.tmo_sel   <= REG_WDATA_I[`AUX_TMO_SEL_HI:`AUX_TMO_SEL_LO];
                ctl.size      <= REG_WDATA_I[`AUX_SIZE_HI:`AUX_SIZE_LO];
                ctl.precharge <= REG_WDATA_I[`AUX_PRE_HI:`AUX_PRE_LO];
                ctl.double_rate_divisor
                    <= REG_WDATA_I[`AUX_DIV_HI:`AUX_DIV_LO];
            end
            if (fin_ok) begin
                ctl.size <= rx_count;
            end
        end
    end

    // sticky flags: set beats a clearing write in the same cycle
    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            flags <= '0;
        end else if (CE_I) begin
            flags.done <= (flags.done
                           && !(wr_ctl && REG_WDATA_I[`AUX_BIT_DONE]))
                          || fin_any;
            flags.tmo <= (flags.tmo
                          && !(wr_ctl && REG_WDATA_I[`AUX_BIT_TMO]))
                         || fin_tmo;
            flags.rx_err <= (flags.rx_err
                             && !(wr_ctl && REG_WDATA_I[`AUX_BIT_RX_ERR]))
                            || fin_err;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            AUX_IRQ_O <= 1'b0;
        end else if (CE_I) begin
            AUX_IRQ_O <= fin_any && ctl.irq_en;
        end
    end

    // registered read data; unmapped indices read zero
    always_ff @(posedge REF_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            REG_RDATA_O <= 32'h00000000;
        end else if (CE_I && REG_RD_I) begin
            if (REG_IDX_I == `AUX_IDX_CTL) begin
                REG_RDATA_O <= {busy, flags.done, ctl.irq_en, flags.tmo,
                                ctl.tmo_sel, flags.rx_err, ctl.size,
                                ctl.precharge, 5'h00,
                                ctl.double_rate_divisor};
            end else if (is_data_idx(REG_IDX_I)) begin
                REG_RDATA_O <= data_word[REG_IDX_I - `AUX_IDX_DATA0];
            end else begin
                REG_RDATA_O <= 32'h00000000;
            end
        end
    end
endmodule : dp_aux_channel_requester
`default_nettype wire

// ==== logic/dp_aux_pkg.sv ====
// types shared by the aux channel requester files
package dp_aux_pkg;

    // sequencer states, one-hot
    typedef enum logic [6:0] {
        ST_IDLE    = 7'b0000001,
        ST_PRECHG  = 7'b0000010,
        ST_SYNC    = 7'b0000100,
        ST_DATA    = 7'b0001000,
        ST_STOP    = 7'b0010000,
        ST_LISTEN  = 7'b0100000,
        ST_RECEIVE = 7'b1000000
    } aux_state_t;

    // software-written control fields
    typedef struct packed {
        logic        irq_en;
        logic [1:0]  tmo_sel;
        logic [4:0]  size;
        logic [3:0]  precharge;
        logic [10:0] double_rate_divisor;
    } aux_ctl_t;

    // sticky status flags
    typedef struct packed {
        logic done;
        logic tmo;
        logic rx_err;
    } aux_flags_t;

endpackage : dp_aux_pkg

// ==== logic/dp_aux_regs.svh ====
// register indices, field positions, reset values and timing for the aux requester
`ifndef DP_AUX_REGS_SVH
`define DP_AUX_REGS_SVH

// register indices on the word-wide register port
`define AUX_IDX_CTL        3'h0
`define AUX_IDX_DATA0      3'h1
`define AUX_IDX_DATA4      3'h5

// control register field positions
`define AUX_BIT_BUSY       31
`define AUX_BIT_DONE       30
`define AUX_BIT_IRQ_EN     29
`define AUX_BIT_TMO        28
`define AUX_TMO_SEL_HI     27
`define AUX_TMO_SEL_LO     26
`define AUX_BIT_RX_ERR     25
`define AUX_SIZE_HI        24
`define AUX_SIZE_LO        20
`define AUX_PRE_HI         19
`define AUX_PRE_LO         16
`define AUX_DIV_HI         10
`define AUX_DIV_LO         0

// reset values
`define AUX_RST_TMO_SEL    2'h0
`define AUX_RST_PRE        4'h5
`define AUX_RST_DIV        11'h014
`define AUX_RST_SIZE       5'h00
`define AUX_RST_DATA       32'h00000000

// timing and framing
`define AUX_REF_CLK_MHZ    40
`define AUX_TMO0_US        400
`define AUX_TMO1_US        600
`define AUX_TMO2_US        800
`define AUX_TMO3_US        1600
`define AUX_PRE_FIXED      6'h1a
`define AUX_SYNC_HALVES    4'h8
`define AUX_SYNC_HIGH      4'h4
`define AUX_MAX_BYTES      5'h14

`endif
